/* pin_sync.sv */
// Two-flop synchroniser for a group of pins.
// Assumes the inputs are asynchronous to MCLK; only the second stage is read.
`timescale 1ns/1ns
module pin_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             MCLK,
    input  wire logic             RESET,
    // Pins and their synchronised copy
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            meta_q  <= RESET_VAL;
            pin_out <= RESET_VAL;
        end else begin
            meta_q  <= pin_in;
            pin_out <= meta_q;
        end
    end

endmodule

/* spi_master_model.sv */
// Serial-bus master model: sends 16-bit frames and captures the reply.
// Assumes MCLK at 40 ns; one serial bit takes 8 MCLK (320 ns, high 4).
`timescale 1ns/1ns
module spi_master_model (
    // Clock
    input  wire logic MCLK,
    // Serial link
    output logic      CS_N,
    output logic      SCLK,
    output logic      SI,
    input  wire logic SO,
    input  wire logic SO_OE
);
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        SI   = 1'b0;
    end

    // SO is only trusted while enabled; otherwise the bit reads unknown
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge MCLK);
        CS_N <= 1'b0;
        repeat (8) @(posedge MCLK);
        for (int i = 15; i >= 0; i--) begin
            // New bit with the rising edge; reply taken just before the fall
            SCLK <= 1'b1;
            SI   <= tx[i];
            repeat (4) @(posedge MCLK);
            rx[i] = SO_OE ? SO : 1'bx;
            SCLK <= 1'b0;
            repeat (4) @(posedge MCLK);
        end
        CS_N <= 1'b1;
        // Idle data line must not look like a held bit
        SI   <= ~SI;
        repeat (10) @(posedge MCLK);
    endtask
endmodule

/* swdec_pkg.sv */
// Constants shared by the serial command decoder of a sixteen-channel switch.
// Assumes one clock domain (MCLK) for everything that reads them.
package swdec_pkg;

    localparam int CHANNELS   = 16;
    localparam int GROUP_SIZE = 8;
    localparam int PAR_PINS   = 4;
    localparam int FRAME_BITS = 16;

    // Upper nibble of the control byte
    localparam logic [3:0] CMD_DIAG = 4'h0;
    localparam logic [3:0] CMD_READ = 4'hc;
    localparam logic [3:0] CMD_ECHO = 4'ha;
    localparam logic [3:0] CMD_OR   = 4'h3;
    localparam logic [3:0] CMD_AND  = 4'hf;

    // Lower nibble of the control byte
    localparam logic [3:0] GRP_LOW  = 4'h0;
    localparam logic [3:0] GRP_HIGH = 4'hf;

    // Two-bit diagnosis codes per channel
    localparam logic [1:0] DIAG_NORMAL   = 2'h3;
    localparam logic [1:0] DIAG_OVERLOAD = 2'h2;
    localparam logic [1:0] DIAG_OPEN     = 2'h1;
    localparam logic [1:0] DIAG_SHORT    = 2'h0;

    // Reset values and the full-frame bit count
    localparam logic [CHANNELS-1:0]   RST_SERIAL = 16'h0000;
    localparam logic                  RST_AND    = 1'b0;
    localparam logic [FRAME_BITS-1:0] RST_SHIFT  = 16'h0000;
    localparam logic [4:0]            FRAME_CNT  = 5'h10;

    // What the next chip-select period shifts out
    typedef enum logic [3:0] {
        RESP_ZERO = 4'b0001,
        RESP_DIAG = 4'b0010,
        RESP_READ = 4'b0100,
        RESP_ECHO = 4'b1000
    } resp_t;

endpackage

/* switch_spi_command_decoder.sv */
// Serial command decoder for a sixteen-channel low-side switch.
// Assumes serial pins arrive asynchronously and are oversampled by MCLK;
// DIAG_CODE comes from same-clock fault logic, two bits per channel.
// What this block does
// - Decode exactly ten control words, others undefined
// - Lower nibble selects channel group
// - Upper nibble zero: diagnosis, outputs unchanged
// - Diagnosis-only lasts one access unless repeated
// - Read-back returns inputs then fault bits
// - Fault bit high means no fault
// - Echo loops serial input to output next period
// - Echo processes nothing; following period reads zero
// - OR command latches OR combining, full diagnosis
// - AND command latches AND combining, full diagnosis
// - Combine mode resets to OR
// - Combine mode latched until other programmed
// - Data bit high switches channel on
// - Undefined word ignored, shift register cleared
// - OR mode lets parallel inputs drive channels
// - Sample input on falling, shift out rising
// - Chip select fall loads, rise transfers
// - Diagnosis codes HH, HL, LH, LL
// - Response appears in following chip-select period
`timescale 1ns/1ns
module switch_spi_command_decoder
    import swdec_pkg::*;
(
    // Clock and reset
    input  wire logic                           MCLK,
    input  wire logic                           RESET,
    // Serial link
    input  wire logic                           CS_N,
    input  wire logic                           SCLK,
    input  wire logic                           SI,
    output logic                                SO,
    output logic                                SO_OE,
    // Parallel control pins
    input  wire logic                           PRG,
    input  wire logic [swdec_pkg::PAR_PINS-1:0] PARALLEL_INPUTS_GROUP_LOW,
    input  wire logic [swdec_pkg::PAR_PINS-1:0] PARALLEL_INPUTS_GROUP_HIGH,
    // Fault logic and output stages
    input  wire logic [2*swdec_pkg::CHANNELS-1:0] DIAG_CODE,
    output logic      [swdec_pkg::CHANNELS-1:0]   CHANNEL_ON,
    output logic                                COMBINE_AND
);
    import swdec_pkg::*;

    logic                  cs_s, sclk_s, si_s, prg_s;
    logic [PAR_PINS-1:0]   pin_lo_s, pin_hi_s;
    logic                  cs_d_q, sclk_d_q;
    logic                  cs_fall, cs_rise, sclk_fall, sclk_rise;
    logic [FRAME_BITS-1:0] sh_q;
    logic [4:0]            cnt_q;
    logic                  so_q, echo_q;
    resp_t                 resp_q;
    logic                  grp_q;
    logic [CHANNELS-1:0]   serial_q;
    logic                  and_q, exec;
    logic [CHANNELS-1:0]   chan_q;

    pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_cs_sync (
        .MCLK    (MCLK),
        .RESET   (RESET),
        .pin_in  (CS_N),
        .pin_out (cs_s)
    );

    // PRG resets high like its pull-up, so no channel blips on after reset
    pin_sync #(.WIDTH(3 + 2 * PAR_PINS), .RESET_VAL(11'h100)) u_pin_sync (
        .MCLK    (MCLK),
        .RESET   (RESET),
        .pin_in  ({SCLK, SI, PRG, PARALLEL_INPUTS_GROUP_LOW,
                   PARALLEL_INPUTS_GROUP_HIGH}),
        .pin_out ({sclk_s, si_s, prg_s, pin_lo_s, pin_hi_s})
    );

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            cs_d_q   <= 1'b1;
            sclk_d_q <= 1'b0;
        end else begin
            cs_d_q   <= cs_s;
            sclk_d_q <= sclk_s;
        end
    end

    assign cs_fall   = cs_d_q & ~cs_s;
    assign cs_rise   = ~cs_d_q & cs_s;
    assign sclk_fall = ~cs_s & sclk_d_q & ~sclk_s;
    assign sclk_rise = ~cs_s & ~sclk_d_q & sclk_s;

    // Received frame decode
    logic [3:0] cmd, grp_bits;
    logic [7:0] data;
    logic       grp_ok, frame_ok, is_diag, is_read, is_echo, is_or, is_and;
    logic       defined;

    assign cmd      = sh_q[15:12];
    assign grp_bits = sh_q[11:8];
    assign data     = sh_q[7:0];
    assign grp_ok   = (grp_bits == GRP_LOW) || (grp_bits == GRP_HIGH);
    assign frame_ok = (cnt_q == FRAME_CNT) && grp_ok;
    assign is_diag  = frame_ok && (cmd == CMD_DIAG);
    assign is_read  = frame_ok && (cmd == CMD_READ);
    assign is_echo  = frame_ok && (cmd == CMD_ECHO);
    assign is_or    = frame_ok && (cmd == CMD_OR);
    assign is_and   = frame_ok && (cmd == CMD_AND);
    assign defined  = is_diag | is_read | is_echo | is_or | is_and;

    // Response image loaded at the falling chip-select edge
    logic [FRAME_BITS-1:0] diag_grp, load_v;
    logic [GROUP_SIZE-1:0] channel_fault_bit;
    logic [PAR_PINS-1:0]   pins_grp;

    assign diag_grp = grp_q ? DIAG_CODE[31:16] : DIAG_CODE[15:0];
    assign pins_grp = grp_q ? pin_hi_s : pin_lo_s;

    for (genvar i = 0; i < GROUP_SIZE; i++) begin : g_fault
        assign channel_fault_bit[i] =
            (diag_grp[2*i+1 -: 2] == DIAG_NORMAL);
    end

    always_comb begin
        load_v = RST_SHIFT;
        unique case (resp_q)
            RESP_ZERO: load_v = RST_SHIFT;
            RESP_DIAG: load_v = diag_grp;
            RESP_READ: load_v = {4'h0, pins_grp, channel_fault_bit};
            RESP_ECHO: load_v = RST_SHIFT;
        endcase
    end

    // Shift register: sample on falling SCLK, reload at frame start
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            sh_q  <= RST_SHIFT;
            cnt_q <= 5'h00;
        end else if (cs_fall) begin
            sh_q  <= load_v;
            cnt_q <= 5'h00;
        end else if (sclk_fall) begin
            sh_q  <= {sh_q[FRAME_BITS-2:0], si_s};
            if (cnt_q != FRAME_CNT) begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end

    // Serial output: MSB at frame start, next bit on rising SCLK
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            so_q  <= 1'b0;
            SO_OE <= 1'b0;
        end else begin
            SO_OE <= ~cs_s;
            if (cs_fall) begin
                so_q <= load_v[FRAME_BITS-1];
            end else if (echo_q && !cs_s) begin
                so_q <= si_s;
            end else if (sclk_rise) begin
                so_q <= sh_q[FRAME_BITS-1];
            end
        end
    end

    assign SO = so_q;

    // Echo loop is closed for exactly one chip-select period
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            echo_q <= 1'b0;
        end else if (cs_fall) begin
            echo_q <= (resp_q == RESP_ECHO);
        end else if (cs_rise) begin
            echo_q <= 1'b0;
        end
    end

    // Pending response set by each completed frame; group only by a defined word outside echo
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            resp_q <= RESP_ZERO;
            grp_q  <= 1'b0;
        end else if (cs_rise) begin
            if (echo_q || !defined) begin
                resp_q <= RESP_ZERO;
            end else begin
                grp_q <= (grp_bits == GRP_HIGH);
                if (is_read) begin
                    resp_q <= RESP_READ;
                end else if (is_echo) begin
                    resp_q <= RESP_ECHO;
                end else begin
                    resp_q <= RESP_DIAG;
                end
            end
        end
    end

    // Serial data bits and combine mode, transferred at frame end
    assign exec = cs_rise && !echo_q && (is_or || is_and);

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            serial_q <= RST_SERIAL;
        end else if (exec) begin
            if (grp_bits == GRP_HIGH) begin
                serial_q[15:8] <= data;
            end else begin
                serial_q[7:0] <= data;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            and_q <= RST_AND;
        end else if (exec) begin
            and_q <= is_and;
        end
    end

    // Output control: parallel pins combine with channels 1-4 and 9-12
    logic [CHANNELS-1:0] chan_d;
    logic [PAR_PINS-1:0] act_lo, act_hi;

    assign act_lo = prg_s ? pin_lo_s : ~pin_lo_s;
    assign act_hi = prg_s ? pin_hi_s : ~pin_hi_s;

    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
        if ((i % GROUP_SIZE) < PAR_PINS) begin : g_par
            logic p;
            assign p = (i < GROUP_SIZE) ? act_lo[i % GROUP_SIZE]
                                        : act_hi[i % GROUP_SIZE];
            assign chan_d[i] = and_q ? (p & serial_q[i])
                                     : (p | serial_q[i]);
        end else begin : g_ser
            assign chan_d[i] = serial_q[i];
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            chan_q      <= RST_SERIAL;
            COMBINE_AND <= RST_AND;
        end else begin
            chan_q      <= chan_d;
            COMBINE_AND <= and_q;
        end
    end

    assign CHANNEL_ON = chan_q;

    // Checks
    a_default_or: assert property (@(posedge MCLK)
        $fell(RESET) |-> !and_q && !COMBINE_AND)
        else $error("combine mode not OR after reset");
    a_mode_latched: assert property (@(posedge MCLK) disable iff (RESET)
        $changed(and_q) |-> $past(exec))
        else $error("combine mode changed without command");
    a_undef_held: assert property (@(posedge MCLK) disable iff (RESET)
        cs_rise && !defined |=> $stable(serial_q) && $stable(and_q))
        else $error("undefined word changed outputs");
    a_undef_zero: assert property (@(posedge MCLK) disable iff (RESET)
        cs_rise && !defined |=> resp_q == RESP_ZERO)
        else $error("undefined word did not clear shift data");
    a_diag_hold: assert property (@(posedge MCLK) disable iff (RESET)
        cs_rise && (is_diag || is_read) |=> $stable(serial_q))
        else $error("diagnosis command changed outputs");
    a_echo_loop: assert property (@(posedge MCLK) disable iff (RESET)
        echo_q && !cs_s && !cs_fall |=> SO == $past(si_s))
        else $error("echo did not loop input to output");
    a_echo_once: assert property (@(posedge MCLK) disable iff (RESET)
        cs_rise && echo_q |=> resp_q == RESP_ZERO && !echo_q)
        else $error("echo not closed after one period");
    a_frame_load: assert property (@(posedge MCLK) disable iff (RESET)
        cs_fall |=> sh_q == $past(load_v) && SO == sh_q[FRAME_BITS-1])
        else $error("shift register not loaded at frame start");
    a_sample_fall: assert property (@(posedge MCLK) disable iff (RESET)
        sclk_fall && !cs_fall |=> sh_q[0] == $past(si_s))
        else $error("input not sampled on falling clock");
    a_or_follow: assert property (@(posedge MCLK) disable iff (RESET)
        !and_q && act_lo[0] |=> CHANNEL_ON[0])
        else $error("parallel input ignored in OR mode");
    a_and_gate: assert property (@(posedge MCLK) disable iff (RESET)
        and_q && !act_hi[1] |=> !CHANNEL_ON[9])
        else $error("AND mode switched channel on");

    c_echo: cover property (@(posedge MCLK) disable iff (RESET)
        echo_q && sclk_rise);
    c_and_mode: cover property (@(posedge MCLK) disable iff (RESET)
        exec && is_and);
    c_readback: cover property (@(posedge MCLK) disable iff (RESET)
        cs_fall && resp_q == RESP_READ);
    c_undefined: cover property (@(posedge MCLK) disable iff (RESET)
        cs_rise && !defined && cnt_q == FRAME_CNT);

endmodule

/* switch_spi_command_decoder_tb.sv */
// Self-checking bench for the serial command decoder.
// Assumes the master model file and the decoder sources are compiled first.
`timescale 1ns/1ns
module switch_spi_command_decoder_tb;
    import swdec_pkg::*;

    logic                  mclk;
    logic                  reset;
    logic                  cs_n;
    logic                  sclk;
    logic                  si;
    logic                  so;
    logic                  so_oe;
    logic                  prg;
    logic [PAR_PINS-1:0]   pins_lo;
    logic [PAR_PINS-1:0]   pins_hi;
    logic [2*CHANNELS-1:0] diag;
    logic [CHANNELS-1:0]   chan_on;
    logic                  comb_and;
    logic [15:0]           rx;
    int                    err_count;
    int                    comparisons;

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    switch_spi_command_decoder i_dut (
        .MCLK                       (mclk),
        .RESET                      (reset),
        .CS_N                       (cs_n),
        .SCLK                       (sclk),
        .SI                         (si),
        .SO                         (so),
        .SO_OE                      (so_oe),
        .PRG                        (prg),
        .PARALLEL_INPUTS_GROUP_LOW  (pins_lo),
        .PARALLEL_INPUTS_GROUP_HIGH (pins_hi),
        .DIAG_CODE                  (diag),
        .CHANNEL_ON                 (chan_on),
        .COMBINE_AND                (comb_and)
    );

    spi_master_model i_part (
        .MCLK  (mclk),
        .CS_N  (cs_n),
        .SCLK  (sclk),
        .SI    (si),
        .SO    (so),
        .SO_OE (so_oe)
    );

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Pins pass a synchroniser, so allow a bounded settling time
    task automatic wait_chan(input logic [15:0] exp);
        int n;
        n = 0;
        while (chan_on !== exp && n < 30) begin
            @(posedge mclk);
            n++;
        end
        if (chan_on !== exp) begin
            check("channels settle", exp, chan_on);
            finish_test();
        end
    endtask

    function automatic logic [7:0] ok_bits(input logic [15:0] d);
        for (int j = 0; j < 8; j++) begin
            ok_bits[j] = (d[2*j +: 2] == DIAG_NORMAL);
        end
    endfunction

    task automatic t_reset();
        check("mode after reset", 16'h0000, {15'h0, comb_and});
        check("enable idle", 16'h0000, {15'h0, so_oe});
        @(posedge mclk);
        pins_lo <= 4'h5;
        wait_chan(16'h0005);
        check("parallel follow", 16'h0005, chan_on);
        @(posedge mclk);
        prg <= 1'b0;
        // Low-active: idle high-group pins switch channels 9 to 12 on too
        wait_chan(16'h0f0a);
        check("low active pins", 16'h0f0a, chan_on);
        @(posedge mclk);
        prg <= 1'b1;
        pins_lo <= 4'h0;
        wait_chan(16'h0000);
    endtask

    task automatic t_serial();
        i_part.frame(16'h3091, rx);
        check("first reply", 16'h0000, rx);
        check("or low data", 16'h0091, chan_on);
        i_part.frame(16'h0fff, rx);
        check("diag low", diag[15:0], rx);
        check("diag keeps out", 16'h0091, chan_on);
        i_part.frame(16'h0f00, rx);
        check("diag high", diag[31:16], rx);
        check("diag keeps out", 16'h0091, chan_on);
    endtask

    task automatic t_and();
        @(posedge mclk);
        pins_lo <= 4'h2;
        pins_hi <= 4'h5;
        wait_chan(16'h0593);
        i_part.frame(16'hff0f, rx);
        check("diag again", diag[31:16], rx);
        check("and mode", 16'h0001, {15'h0, comb_and});
        check("and outputs", 16'h0590, chan_on);
        i_part.frame(16'hcf00, rx);
        check("and reply", diag[31:16], rx);
        i_part.frame(16'h0000, rx);
        check("read back", {4'h0, pins_hi, ok_bits(diag[31:16])}, rx);
        check("read keeps out", 16'h0590, chan_on);
    endtask

    task automatic t_echo();
        i_part.frame(16'ha000, rx);
        check("before echo", diag[15:0], rx);
        i_part.frame(16'h30ff, rx);
        check("echo loop", 16'h30ff, rx);
        check("echo no action", 16'h0590, chan_on);
        i_part.frame(16'h0000, rx);
        check("after echo", 16'h0000, rx);
    endtask

    task automatic t_undef();
        logic [7:0] bad [4] = '{8'h70, 8'h35, 8'h0a, 8'h5f};
        foreach (bad[k]) begin
            i_part.frame({bad[k], 8'hff}, rx);
            check("reply before", diag[15:0], rx);
            check("undefined outs", 16'h0590, chan_on);
            i_part.frame(16'h0000, rx);
            check("cleared reply", 16'h0000, rx);
        end
    endtask

    task automatic t_mode();
        i_part.frame(16'hf000, rx);
        check("and low", 16'h0500, chan_on);
        check("mode held", 16'h0001, {15'h0, comb_and});
        i_part.frame(16'h3f00, rx);
        check("or restored", 16'h0000, {15'h0, comb_and});
        check("or outputs", 16'h0502, chan_on);
        i_part.frame(16'hc000, rx);
        check("or reply", diag[31:16], rx);
        i_part.frame(16'h0000, rx);
        check("read low", {4'h0, pins_lo, ok_bits(diag[15:0])}, rx);
    endtask

    initial begin
        reset = 1'b1;
        prg = 1'b1;
        pins_lo = '0;
        pins_hi = '0;
        diag = 32'hf39c_4e27;
        err_count = 0;
        comparisons = 0;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        t_reset();
        t_serial();
        t_and();
        t_echo();
        t_undef();
        t_mode();
        finish_test();
    end
endmodule
